// file: dac_refresh_defs.svh
// Constants for the output refresh engine
//
// Summary of operation
// R01 - Program keeps each output in fixed word
// R02 - Copy every output word eighty times per second
// R03 - Copy during second and fourth drum quarter
// R04 - One memory access per machine cycle slot
// R05 - Access only slots unclaimed by other users
// R06 - Other users leave 192 free slots
// R07 - Address counter advances per access, stops done
// R08 - Take sign and ten top magnitude bits
// R09 - Sign bit always inverted on load
// R10 - Negative word inverts all magnitude bits
// R11 - Twelfth bit complemented for negative words
// R12 - Coded word written into next buffer word
// R13 - Buffer write only sets one bits
// R14 - Reading a buffer bit clears it
// R15 - Read one bit of all words, LSB first
// R16 - Binary weighted dwell, six microsecond base
// R17 - Channel flip-flop holds bit, drives switch
// R18 - Sweep per half revolution, write after read
`ifndef DAC_REFRESH_DEFS_SVH
`define DAC_REFRESH_DEFS_SVH

`define DAC_CHANNELS       192
`define OUT_BITS           12
`define MEM_WORD_BITS      24
`define MEM_ADDR_BITS      11
`define MEM_SIGN_BIT       23
`define MEM_MAG_HI         22
`define MEM_MAG_LO         13
`define MEM_ROUND_BIT      12
`define OUT_SIGN_POS       11
`define REFRESH_HZ         80
`define DRUM_REV_PER_S     40
`define CLK_PERIOD_NS      100
`define MACHINE_CYCLE_NS   6100
`define SLOT_CYCLES        ((`MACHINE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUARTER_SLOTS      1024
`define DWELL_LSB_NS       6000
`define DWELL_UNIT_CYCLES  (`DWELL_LSB_NS / `CLK_PERIOD_NS)
`define SIGN_DWELL_UNITS   1024
`define SWEEP_UNITS        2048

`endif

// file: dac_refresh_pkg.sv
// Types shared by the output refresh engine
package dac_refresh_pkg;

   typedef enum {SW_IDLE, SW_READ} sweep_state_e;

   typedef logic [11:0] out_word_t;

endpackage : dac_refresh_pkg

// file: word_coder.sv
// Coding stage from memory word to output register word
`timescale 1ns/1ps
`include "dac_refresh_defs.svh"

module word_coder
   import dac_refresh_pkg::*;
(
   input  wire logic [`MEM_WORD_BITS-1:0] mem_word,
   output out_word_t                      coded
);

   logic sign;

   assign sign = mem_word[`MEM_SIGN_BIT];

   // Lower memory bits are dropped without rounding
   assign coded[`OUT_SIGN_POS] = ~sign; // R09
   assign coded[10:1] = mem_word[`MEM_MAG_HI:`MEM_MAG_LO] ^ {10{sign}}; // R08 R10
   assign coded[0] = mem_word[`MEM_ROUND_BIT] ^ sign; // R11

endmodule : word_coder

// file: buffer_store.sv
// Buffer word store: set-only word write, clear-on-read bit column
`timescale 1ns/1ps
`include "dac_refresh_defs.svh"

module buffer_store
   import dac_refresh_pkg::*;
#(
   parameter int CHANNELS = `DAC_CHANNELS
)(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                wr_en,
   input  wire logic [7:0]          wr_index,
   input  wire out_word_t           wr_data,
   input  wire logic                rd_en,
   input  wire logic [3:0]          rd_bit,
   output logic      [CHANNELS-1:0] rd_col
);

   if (CHANNELS < 1 || CHANNELS > 256)
      $error("buffer_store: CHANNELS must lie in 1..256");

   out_word_t store     [CHANNELS];
   out_word_t next_store[CHANNELS];

   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         next_store[i] = store[i];
         if (rd_en)
            next_store[i][rd_bit] = 1'b0; // R14
         // Set wins over a clear in the same cycle, so nothing written is lost
         if (wr_en && wr_index == 8'(i))
            next_store[i] = next_store[i] | wr_data; // R12 R13
      end
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (sys_rst)
            store[i] <= '0;
         else
            store[i] <= next_store[i];
      end
   end

   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
         rd_col[i] = store[i][rd_bit]; // R15
   end

endmodule : buffer_store

// file: dac_output_refresh.sv
// Output refresh engine: memory copy, coding, buffer and weighted readout
`timescale 1ns/1ps
`include "dac_refresh_defs.svh"

module dac_output_refresh
   import dac_refresh_pkg::*;
#(
   parameter int                      CHANNELS      = `DAC_CHANNELS,
   parameter int                      ADDR_W        = `MEM_ADDR_BITS,
   parameter logic [ADDR_W-1:0]       BASE_ADDR     = '0,
   parameter int                      QUARTER_SLOTS = `QUARTER_SLOTS,
   parameter int                      DWELL_UNIT    = `DWELL_UNIT_CYCLES
)(
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      busy_main,
   input  wire logic                      busy_interp,
   input  wire logic                      busy_radio,
   input  wire logic [`MEM_WORD_BITS-1:0] mem_rdata,
   output logic                           mem_rd_en,
   output logic      [ADDR_W-1:0]         mem_addr,
   output logic      [CHANNELS-1:0]       ch_level,
   output logic      [3:0]                sweep_bit
);

   localparam int SLOT_LAST = `SLOT_CYCLES - 1;

   // Eight-bit word index must be able to count up to CHANNELS
   if (CHANNELS < 1 || CHANNELS > 255 || CHANNELS > QUARTER_SLOTS)
      $error("dac_output_refresh: CHANNELS out of range");
   if (ADDR_W < 8 || int'(BASE_ADDR) + CHANNELS > (1 << ADDR_W))
      $error("dac_output_refresh: output block does not fit the address space");
   if (DWELL_UNIT < 2)
      $error("dac_output_refresh: DWELL_UNIT must be at least 2");
   // Sign bit must be captured before the copy quarter opens
   if (`SIGN_DWELL_UNITS * DWELL_UNIT >= QUARTER_SLOTS * `SLOT_CYCLES)
      $error("dac_output_refresh: sweep does not fit the read quarter");
   if (`SWEEP_UNITS * DWELL_UNIT > 2 * QUARTER_SLOTS * `SLOT_CYCLES)
      $error("dac_output_refresh: sweep longer than half a revolution");

   function automatic logic [31:0] dwell_cycles(input logic [3:0] pos);
      logic [31:0] units;
      units = (pos == 4'h0) ? 32'h1 : (32'h1 << (pos - 4'h1));
      return units * 32'(DWELL_UNIT);
   endfunction : dwell_cycles

   logic [6:0]    cyc;
   logic [15:0]   slot;
   logic [1:0]    quarter;
   logic          slot_start;
   logic          slot_end;
   logic          sweep_start;
   logic          copy_quarter;
   logic          free_slot;
   logic          grab;
   logic          capture;
   logic [7:0]    word_idx;
   out_word_t     coded;
   out_word_t     wr_data;
   logic [7:0]    wr_index;
   logic          wr_en;
   sweep_state_e  state;
   logic          rd_en;
   logic [31:0]   dwell_cnt;
   logic          read_done;
   logic [CHANNELS-1:0] rd_col;
   logic [31:0]   gap;

   // Machine cycle slots, quarters and revolutions
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cyc     <= '0;
         slot    <= '0;
         quarter <= '0;
      end
      else if (slot_end)
      begin
         cyc <= '0;
         if (slot == 16'(QUARTER_SLOTS - 1))
         begin
            slot    <= '0;
            quarter <= quarter + 2'h1;
         end
         else
            slot <= slot + 16'h1;
      end
      else
         cyc <= cyc + 7'h1;
   end

   assign slot_start   = (cyc == 7'h00);
   assign slot_end     = (cyc == 7'(SLOT_LAST));
   assign sweep_start  = slot_start && slot == 16'h0000 && !quarter[0]; // R18
   assign copy_quarter = quarter[0]; // R03
   assign free_slot    = !(busy_main || busy_interp || busy_radio); // R05

   // Claims are only looked at on a slot boundary, so one slot gives one access
   assign grab = slot_start && copy_quarter && read_done && free_slot
              && word_idx < 8'(CHANNELS) && !mem_rd_en; // R04 R05 R18
   assign capture = mem_rd_en && slot_end;

   // Address counter
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         word_idx <= '0;
      else if (sweep_start)
         word_idx <= '0;
      else if (capture)
         word_idx <= word_idx + 8'h1; // R07
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mem_rd_en <= 1'b0;
      else if (grab)
         mem_rd_en <= 1'b1; // R02 R04
      else if (capture)
         mem_rd_en <= 1'b0;
   end

   // Address is held between accesses until a free slot arrives
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mem_addr <= '0;
      else if (grab)
         mem_addr <= ADDR_W'(BASE_ADDR + ADDR_W'(word_idx)); // R07
   end

   word_coder u_coder (
      .mem_word (mem_rdata),
      .coded    (coded)
   );

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_en    <= 1'b0;
         wr_data  <= '0;
         wr_index <= '0;
      end
      else
      begin
         wr_en <= capture; // R12
         if (capture)
         begin
            wr_data  <= coded;
            wr_index <= word_idx;
         end
      end
   end

   buffer_store #(
      .CHANNELS (CHANNELS)
   ) u_store (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .wr_en    (wr_en),
      .wr_index (wr_index),
      .wr_data  (wr_data),
      .rd_en    (rd_en),
      .rd_bit   (sweep_bit),
      .rd_col   (rd_col)
   );

   // Readout sweep, least significant bit first
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state     <= SW_IDLE;
         sweep_bit <= '0;
         rd_en     <= 1'b0;
         dwell_cnt <= '0;
      end
      else if (sweep_start)
      begin
         state     <= SW_READ;
         sweep_bit <= '0; // R15
         rd_en     <= 1'b1;
         dwell_cnt <= '0;
      end
      else
      begin
         unique case (state)
            SW_IDLE:
            begin
               rd_en <= 1'b0;
            end
            SW_READ:
            begin
               if (dwell_cnt == dwell_cycles(sweep_bit) - 32'h1) // R16
               begin
                  dwell_cnt <= '0;
                  if (sweep_bit == 4'(`OUT_SIGN_POS))
                  begin
                     state <= SW_IDLE;
                     rd_en <= 1'b0;
                  end
                  else
                  begin
                     sweep_bit <= sweep_bit + 4'h1; // R15
                     rd_en     <= 1'b1;
                  end
               end
               else
               begin
                  dwell_cnt <= dwell_cnt + 32'h1;
                  rd_en     <= 1'b0;
               end
            end
         endcase
      end
   end

   // Copying waits for the sign column, the last one cleared in a sweep
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         read_done <= 1'b0;
      else if (sweep_start)
         read_done <= 1'b0;
      else if (rd_en && sweep_bit == 4'(`OUT_SIGN_POS))
         read_done <= 1'b1; // R18
   end

   // Channel flip-flops; between sweeps they hold the sign bit
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ch_level <= '0;
      else if (rd_en)
         ch_level <= rd_col; // R17
   end

   // Helper: cycles since the last column read
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         gap <= '0;
      else if (rd_en)
         gap <= 32'h1;
      else if (gap != 32'hffffffff)
         gap <= gap + 32'h1;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_capture;
      mem_rd_en && slot_end;
   endsequence

   sequence s_grab;
      $rose(mem_rd_en);
   endsequence

   property p_slot_aligned;
      s_grab |-> (cyc == 7'h01);
   endproperty
   a_slot_aligned: assert property (p_slot_aligned) else $error("Access not slot aligned"); // R04

   property p_free_only;
      s_grab |-> $past(!(busy_main || busy_interp || busy_radio));
   endproperty
   a_free_only: assert property (p_free_only) else $error("Access in claimed slot"); // R05

   property p_copy_quarter;
      mem_rd_en |-> quarter[0];
   endproperty
   a_copy_quarter: assert property (p_copy_quarter) else $error("Access outside copy quarter"); // R03

   property p_advance;
      s_capture |=> (word_idx == $past(word_idx) + 8'h1) && !mem_rd_en;
   endproperty
   a_advance: assert property (p_advance) else $error("Address counter did not advance"); // R07

   property p_stop;
      s_grab |-> (word_idx < 8'(CHANNELS))
              && (mem_addr == ADDR_W'(BASE_ADDR + ADDR_W'(word_idx)));
   endproperty
   a_stop: assert property (p_stop) else $error("Access beyond last output word"); // R07

   property p_write_after;
      s_capture |=> wr_en && wr_index == $past(word_idx);
   endproperty
   a_write_after: assert property (p_write_after) else $error("Buffer write misplaced"); // R12

   property p_sign_inv;
      s_capture |=> wr_data[`OUT_SIGN_POS] == !$past(mem_rdata[`MEM_SIGN_BIT]);
   endproperty
   a_sign_inv: assert property (p_sign_inv) else $error("Sign not inverted"); // R09

   property p_mag_code;
      s_capture |=> wr_data[10:1] == ($past(mem_rdata[`MEM_SIGN_BIT])
                                      ? ~$past(mem_rdata[`MEM_MAG_HI:`MEM_MAG_LO])
                                      : $past(mem_rdata[`MEM_MAG_HI:`MEM_MAG_LO]));
   endproperty
   a_mag_code: assert property (p_mag_code) else $error("Magnitude coding wrong"); // R08 R10

   property p_round_bit;
      s_capture |=> wr_data[0] == ($past(mem_rdata[`MEM_ROUND_BIT])
                                   ^ $past(mem_rdata[`MEM_SIGN_BIT]));
   endproperty
   a_round_bit: assert property (p_round_bit) else $error("Twelfth bit coding wrong"); // R11

   property p_sweep_begin;
      sweep_start |=> rd_en && sweep_bit == 4'h0;
   endproperty
   a_sweep_begin: assert property (p_sweep_begin) else $error("Sweep did not start at LSB"); // R15

   property p_capture_ch;
      rd_en |=> ch_level == $past(rd_col);
   endproperty
   a_capture_ch: assert property (p_capture_ch) else $error("Channel flip-flops missed column"); // R17

   property p_clear_read;
      rd_en |=> (rd_col == '0);
   endproperty
   a_clear_read: assert property (p_clear_read) else $error("Column not cleared by read"); // R14

   property p_dwell;
      rd_en && sweep_bit != 4'h0 |-> gap == dwell_cycles(sweep_bit - 4'h1);
   endproperty
   a_dwell: assert property (p_dwell) else $error("Bit dwell time wrong"); // R16

   property p_write_gate;
      wr_en |-> read_done && cyc == 7'h00 && (quarter[0] || slot == 16'h0000);
   endproperty
   a_write_gate: assert property (p_write_gate) else $error("Write before column read"); // R18

endmodule : dac_output_refresh

// file: core_mem_model.sv
// Main core memory model seen through the priority access path
`timescale 1ns/1ps
`include "dac_refresh_defs.svh"

module core_mem_model #(
   parameter int ADDR_W = 11,
   parameter int DELAY  = 50
)(
   input  wire logic                      clk,
   input  wire logic                      mem_rd_en,
   input  wire logic [ADDR_W-1:0]         mem_addr,
   output logic      [`MEM_WORD_BITS-1:0] mem_rdata,
   input  wire logic                      ld_en,
   input  wire logic [ADDR_W-1:0]         ld_addr,
   input  wire logic [`MEM_WORD_BITS-1:0] ld_data
);
   logic [`MEM_WORD_BITS-1:0] words [2**ADDR_W];
   int                        wait_cnt;

   initial mem_rdata = 24'h5a5a5a;

   // Slow answer: data shows only late in the read, toggling junk before and after
   always @(posedge clk)
   begin
      if (ld_en)
         words[ld_addr] <= ld_data;
      wait_cnt <= mem_rd_en ? wait_cnt + 1 : 0;
      if (mem_rd_en && wait_cnt >= DELAY)
         mem_rdata <= words[mem_addr];
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule : core_mem_model

// file: dac_output_refresh_test.sv
// Testbench for the output refresh engine
`timescale 1ns/1ps
`include "dac_refresh_defs.svh"

module dac_output_refresh_test
   import dac_refresh_pkg::*;
   ;
   // Shortened quarter still leaves room for 192 reads plus the claimed slots
   localparam int          QS   = 256;
   localparam int          DW   = 2;
   localparam int          SLOT = 61;
   localparam int          N    = 10;
   localparam int          CH   = `DAC_CHANNELS;
   localparam logic [10:0] BASE = 11'h200;

   logic              clk;
   logic              sys_rst;
   logic              busy_main;
   logic              busy_interp;
   logic              busy_radio;
   logic [23:0]       mem_rdata;
   logic              mem_rd_en;
   logic [10:0]       mem_addr;
   logic [CH-1:0]     ch_level;
   logic [3:0]        sweep_bit;
   logic              ld_en;
   logic [10:0]       ld_addr;
   logic [23:0]       ld_data;
   logic              live;
   bit                done;
   bit                rd_prev;
   bit                have;
   int                n;
   int                e;
   int                idx;
   int                hi;
   int                sw_no;
   int                last_p;
   int                chk_p;
   int                t_last;
   int                num_errors;
   int                checked;

   logic [23:0] tab_in  [N] = '{24'h000000, 24'h800000, 24'h7fffff, 24'hffffff, 24'h001000,
                                24'h801000, 24'h400000, 24'h2aa555, 24'hd55000, 24'h000fff};
   out_word_t   tab_out [N] = '{12'h800, 12'h7ff, 12'hfff, 12'h000, 12'h801,
                                12'h7fe, 12'hc00, 12'haaa, 12'h2aa, 12'h800};

   dac_output_refresh #(.CHANNELS(CH), .ADDR_W(11), .BASE_ADDR(BASE), .QUARTER_SLOTS(QS),
                        .DWELL_UNIT(DW)) dac_output_refresh_i (
      .clk(clk), .sys_rst(sys_rst), .busy_main(busy_main), .busy_interp(busy_interp),
      .busy_radio(busy_radio), .mem_rdata(mem_rdata), .mem_rd_en(mem_rd_en),
      .mem_addr(mem_addr), .ch_level(ch_level), .sweep_bit(sweep_bit));

   core_mem_model #(.ADDR_W(11), .DELAY(50)) core_mem_model_i (
      .clk(clk), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data));

   always #50 clk = ~clk;

   function automatic int quarter(input int t);
      return (t / SLOT / QS) % 4;
   endfunction : quarter

   // Claims sit on slots 2..7 of odd quarters, costing six slots of the spare margin
   function automatic logic [2:0] busy_fn(input int t);
      int s;
      bit q;
      s = (t / SLOT) % QS;
      q = quarter(t) % 2 == 1;
      return {q && (s == 2 || s == 3), q && (s == 4 || s == 5), q && (s == 6 || s == 7)};
   endfunction : busy_fn

   function automatic int dwell(input int p);
      return (p == 0) ? DW : DW << (p - 1);
   endfunction : dwell

   function automatic logic [CH-1:0] exp_col(input int sw, input int p);
      logic [CH-1:0] v;
      out_word_t     w;
      for (int i = 0; i < CH; i++)
      begin
         w = (sw == 0) ? 12'h000 : tab_out[(i + sw - 1) % N];
         v[i] = w[p];
      end
      return v;
   endfunction : exp_col

   task automatic cmp(input string what, input logic [CH-1:0] exp, input logic [CH-1:0] got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic cmp_cnt(input string what, input int exp, input int got);
      checked++;
      if (got != exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask : cmp_cnt

   task automatic load(input int shift);
      for (int i = 0; i < CH; i++)
      begin
         ld_en = 1'b1;
         ld_addr = BASE + 11'(i);
         ld_data = tab_in[(i + shift) % N];
         @(posedge clk);
         #1;
      end
      ld_en = 1'b0;
   endtask : load

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   always @(posedge clk)
   begin
      n <= sys_rst ? 0 : n + 1;
      live <= !sys_rst;
   end

   always @(posedge clk)
   begin
      #1;
      {busy_main, busy_interp, busy_radio} = busy_fn(n);
   end

   always @(posedge clk)
   begin
      #2;
      e = n - 1;
      if (!live)
      begin
         idx = 0;
         hi = 0;
         rd_prev = 0;
         have = 0;
         sw_no = 0;
         last_p = 0;
         chk_p = -1;
      end
      else
      begin
         if (mem_rd_en)
            hi++;
         if (mem_rd_en && !rd_prev)
         begin
            cmp_cnt("grant", 1, int'(e % SLOT == 0 && busy_fn(e) == 0 && quarter(e) % 2 == 1));
            cmp("address", CH'(BASE + 11'(idx)), CH'(mem_addr));
            idx++;
         end
         if (!mem_rd_en && rd_prev)
         begin
            cmp_cnt("read length", 60, hi);
            hi = 0;
         end
         if (e > 0 && e % (QS * SLOT) == 0 && quarter(e) % 2 == 0)
         begin
            cmp_cnt("words per pass", CH, idx);
            idx = 0;
         end
         rd_prev = mem_rd_en;
         if (chk_p >= 0)
         begin
            cmp("column", exp_col(sw_no, chk_p), ch_level);
            done = done || (sw_no == 2 && chk_p == 11);
            chk_p = -1;
         end
         if (int'(sweep_bit) != last_p)
         begin
            if (have && last_p != 11)
               cmp_cnt("dwell", dwell(last_p), e - t_last);
            cmp("bit order", CH'((last_p + 1) % 12), CH'(sweep_bit));
            if (sweep_bit == 4'h0)
            begin
               sw_no++;
               cmp_cnt("sweep quarter", 0, quarter(e) % 2);
            end
            chk_p = int'(sweep_bit);
            have = 1;
            t_last = e;
            last_p = int'(sweep_bit);
         end
      end
   end

   initial
   begin
      repeat (80000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial
   begin
      clk = 0;
      sys_rst = 1;
      {busy_main, busy_interp, busy_radio} = 3'h0;
      {ld_en, ld_addr, ld_data} = '0;
      repeat (10) @(posedge clk);
      #1;
      sys_rst = 0;
      load(0);
      while (n < 2 * QS * SLOT) @(posedge clk);
      #1;
      // Rotated words make stale buffer bits visible in the next sweep
      load(1);
      while (!done) @(posedge clk);
      #1;
      sys_rst = 1;
      @(posedge clk);
      #1;
      cmp("reset rd_en", '0, CH'(mem_rd_en));
      cmp("reset sweep", '0, CH'(sweep_bit));
      cmp("reset level", '0, ch_level);
      sys_rst = 0;
      repeat (4300) @(posedge clk);
      wrap_up();
   end
endmodule : dac_output_refresh_test
